/* File: adpm_pad_model.sv */
// Far side of the pin mux: comparator outputs and the pad levels.
// Assumes the bench sets comparator levels and outside pin levels.
`timescale 1ns/1ps
`default_nettype none
module adpm_pad_model (
	input  wire adpm_pkg::adpm_dig_drive_t dig_drv_i,
	input  wire adpm_pkg::adpm_ana_drive_t ana_drv_i,
	input  wire logic [5:0]                cmp_set_i,
	input  wire logic [7:0]                dig_ext_i,
	input  wire logic [11:0]               ana_ext_i,
	output var  logic [5:0]                cmp_o,
	output var  logic [7:0]                dig_pad_o,
	output var  logic [11:0]               ana_pad_o
);
	import adpm_pkg::*;
	assign cmp_o = cmp_set_i;
	// Driven pin shows the mux level; an enabled pullup lifts an idle pin
	assign dig_pad_o = (dig_drv_i.oe & dig_drv_i.out) |
		(~dig_drv_i.oe & (dig_drv_i.pullup_en | dig_ext_i));
	// Software enables one destination per analog pin; analog_sel stands for that one
	assign ana_pad_o = (ana_drv_i.oe & ana_drv_i.out) | (~ana_drv_i.oe & ana_ext_i);
endmodule
`default_nettype wire

/* File: adpm_pin_mux.sv */
// Pin mux for an eight-pin digital group and a twelve-pin analog group.
// Assumes an AXI4-Lite master; awuser/aruser high marks the control CPU.
`timescale 1ns/1ps
`default_nettype none
module adpm_pin_mux (
	input  wire logic                           mclk_i,
	input  wire logic                           arst_n_i,
	// AXI4-Lite slave
	input  wire logic [adpm_pkg::ADPM_AW-1:0]   s_axi_awaddr_i,
	input  wire logic                           s_axi_awuser_i,
	input  wire logic                           s_axi_awvalid_i,
	output var  logic                           s_axi_awready_o,
	input  wire logic [31:0]                    s_axi_wdata_i,
	input  wire logic [3:0]                     s_axi_wstrb_i,
	input  wire logic                           s_axi_wvalid_i,
	output var  logic                           s_axi_wready_o,
	output var  logic [1:0]                     s_axi_bresp_o,
	output var  logic                           s_axi_bvalid_o,
	input  wire logic                           s_axi_bready_i,
	input  wire logic [adpm_pkg::ADPM_AW-1:0]   s_axi_araddr_i,
	input  wire logic                           s_axi_aruser_i,
	input  wire logic                           s_axi_arvalid_i,
	output var  logic                           s_axi_arready_o,
	output var  logic [31:0]                    s_axi_rdata_o,
	output var  logic [1:0]                     s_axi_rresp_o,
	output var  logic                           s_axi_rvalid_o,
	input  wire logic                           s_axi_rready_i,
	// Comparator outputs, same clock
	input  wire logic [adpm_pkg::ADPM_COMPS-1:0] comparator_output_i,
	// Digital group pins
	input  wire logic [adpm_pkg::ADPM_DIG_PINS-1:0] digital_pin_group_i,
	output var  adpm_pkg::adpm_dig_drive_t      digital_pin_group_o,
	// Analog group pins
	input  wire logic [adpm_pkg::ADPM_ANA_PINS-1:0] analog_pin_group_i,
	output var  adpm_pkg::adpm_ana_drive_t      analog_pin_group_o
);
	import adpm_pkg::*;

	logic [31:0] dig_mode_reg;
	logic [31:0] dig_pud_reg;
	logic [31:0] dig_data_reg;
	logic [31:0] dig_dir_reg;
	logic [31:0] ana_mode_reg;
	logic [31:0] ana_data_reg;
	logic [31:0] ana_dir_reg;

	logic [ADPM_DIG_PINS-1:0] dig_in_sync;
	logic [ADPM_ANA_PINS-1:0] ana_in_sync;
	logic [ADPM_LINES-1:0]    line_in;

	logic                aw_held_reg;
	logic [ADPM_AW-1:0]  aw_addr_reg;
	logic                aw_ctl_reg;
	logic                w_held_reg;
	logic [31:0]         w_data_reg;
	logic [3:0]          w_strb_reg;
	logic                do_write;

	adpm_dig_drive_t dig_next;
	adpm_ana_drive_t ana_next;

	adpm_sync3 #(.W(ADPM_DIG_PINS)) u_dig_sync (
		.mclk_i   (mclk_i),
		.arst_n_i (arst_n_i),
		.async_i  (digital_pin_group_i),
		.level_o  (dig_in_sync)
	);

	adpm_sync3 #(.W(ADPM_ANA_PINS)) u_ana_sync (
		.mclk_i   (mclk_i),
		.arst_n_i (arst_n_i),
		.async_i  (analog_pin_group_i),
		.level_o  (ana_in_sync)
	);

	function automatic logic [31:0] merge_bytes(input logic [31:0] old, input logic [31:0] data,
		input logic [3:0] strb, input logic [31:0] mask);
		logic [31:0] res;
		res = old;
		for (int b = 0; b < 4; b++)
			if (strb[b])
				res[8*b +: 8] = data[8*b +: 8];
		return res & mask;
	endfunction

	function automatic logic addr_is(input logic [ADPM_AW-1:0] addr, input logic [ADPM_AW-1:0] ofs);
		return addr[ADPM_AW-1:2] == ofs[ADPM_AW-1:2];
	endfunction

	function automatic logic addr_mapped(input logic [ADPM_AW-1:0] addr);
		return addr_is(addr, ADPM_DIG_MODE_OFS) || addr_is(addr, ADPM_DIG_PUD_OFS)
			|| addr_is(addr, ADPM_DIG_DATA_OFS) || addr_is(addr, ADPM_DIG_DIR_OFS)
			|| addr_is(addr, ADPM_ANA_MODE_OFS) || addr_is(addr, ADPM_ANA_DATA_OFS)
			|| addr_is(addr, ADPM_ANA_DIR_OFS);
	endfunction

	// Gather the digital line levels from the analog pins
	always_comb
	begin
		line_in = '0;
		for (int p = 0; p < ADPM_ANA_PINS; p++)
			if (ADPM_ANA_LINE[p] >= 0)
				line_in[ADPM_ANA_LINE[p]] = ana_in_sync[p];
	end

	// Write channel: address and data taken in either order
	assign do_write = aw_held_reg && w_held_reg && !s_axi_bvalid_o;

	always_ff @(posedge mclk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			aw_held_reg     <= 1'b0;
			aw_addr_reg     <= '0;
			aw_ctl_reg      <= 1'b0;
			s_axi_awready_o <= 1'b1;
		end
		else if (s_axi_awvalid_i && s_axi_awready_o)
		begin
			aw_held_reg     <= 1'b1;
			aw_addr_reg     <= s_axi_awaddr_i;
			aw_ctl_reg      <= s_axi_awuser_i;
			s_axi_awready_o <= 1'b0;
		end
		else if (s_axi_bvalid_o && s_axi_bready_i)
		begin
			aw_held_reg     <= 1'b0;
			s_axi_awready_o <= 1'b1;
		end
	end

	always_ff @(posedge mclk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			w_held_reg     <= 1'b0;
			w_data_reg     <= '0;
			w_strb_reg     <= '0;
			s_axi_wready_o <= 1'b1;
		end
		else if (s_axi_wvalid_i && s_axi_wready_o)
		begin
			w_held_reg     <= 1'b1;
			w_data_reg     <= s_axi_wdata_i;
			w_strb_reg     <= s_axi_wstrb_i;
			s_axi_wready_o <= 1'b0;
		end
		else if (s_axi_bvalid_o && s_axi_bready_i)
		begin
			w_held_reg     <= 1'b0;
			s_axi_wready_o <= 1'b1;
		end
	end

	always_ff @(posedge mclk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			s_axi_bvalid_o <= 1'b0;
			s_axi_bresp_o  <= ADPM_RESP_OKAY;
		end
		else if (do_write)
		begin
			s_axi_bvalid_o <= 1'b1;
			if (!addr_mapped(aw_addr_reg))
				s_axi_bresp_o <= ADPM_RESP_DECERR;
			else if (!aw_ctl_reg)
				s_axi_bresp_o <= ADPM_RESP_SLVERR;
			else
				s_axi_bresp_o <= ADPM_RESP_OKAY;
		end
		else if (s_axi_bready_i)
			s_axi_bvalid_o <= 1'b0;
	end

	// Digital group configuration, control CPU only
	always_ff @(posedge mclk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			dig_mode_reg <= ADPM_DIG_MODE_RST; // [R3]
			dig_pud_reg  <= ADPM_DIG_PUD_RST;
			dig_data_reg <= '0;
			dig_dir_reg  <= ADPM_DIR_RST;
		end
		else if (do_write && aw_ctl_reg) // [R4]
		begin
			if (addr_is(aw_addr_reg, ADPM_DIG_MODE_OFS))
				dig_mode_reg <= merge_bytes(dig_mode_reg, w_data_reg, w_strb_reg,
					ADPM_DIG_MODE_MSK); // [R5]
			else if (addr_is(aw_addr_reg, ADPM_DIG_PUD_OFS))
				dig_pud_reg <= merge_bytes(dig_pud_reg, w_data_reg, w_strb_reg,
					ADPM_DIG_8_MSK); // [R2]
			else if (addr_is(aw_addr_reg, ADPM_DIG_DATA_OFS))
				dig_data_reg <= merge_bytes(dig_data_reg, w_data_reg, w_strb_reg,
					ADPM_DIG_8_MSK); // [R9]
			else if (addr_is(aw_addr_reg, ADPM_DIG_DIR_OFS))
				dig_dir_reg <= merge_bytes(dig_dir_reg, w_data_reg, w_strb_reg,
					ADPM_DIG_8_MSK); // [R9]
		end
	end

	// Analog group configuration, control CPU only; even mode bits dropped
	always_ff @(posedge mclk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			ana_mode_reg <= ADPM_ANA_MODE_RST; // [R11]
			ana_data_reg <= '0;
			ana_dir_reg  <= ADPM_DIR_RST;
		end
		else if (do_write && aw_ctl_reg) // [R12]
		begin
			if (addr_is(aw_addr_reg, ADPM_ANA_MODE_OFS))
				ana_mode_reg <= merge_bytes(ana_mode_reg, w_data_reg, w_strb_reg,
					ADPM_ANA_MODE_MSK); // [R14]
			else if (addr_is(aw_addr_reg, ADPM_ANA_DATA_OFS))
				ana_data_reg <= merge_bytes(ana_data_reg, w_data_reg, w_strb_reg,
					ADPM_LINE_MSK); // [R17]
			else if (addr_is(aw_addr_reg, ADPM_ANA_DIR_OFS))
				ana_dir_reg <= merge_bytes(ana_dir_reg, w_data_reg, w_strb_reg,
					ADPM_LINE_MSK); // [R17]
		end
	end

	// Read channel: one-cycle answer, data registers return pin levels
	always_ff @(posedge mclk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			s_axi_arready_o <= 1'b1;
			s_axi_rvalid_o  <= 1'b0;
			s_axi_rdata_o   <= '0;
			s_axi_rresp_o   <= ADPM_RESP_OKAY;
		end
		else if (s_axi_arvalid_i && s_axi_arready_o)
		begin
			s_axi_arready_o <= 1'b0;
			s_axi_rvalid_o  <= 1'b1;
			s_axi_rdata_o   <= '0;
			s_axi_rresp_o   <= ADPM_RESP_OKAY;
			if (!addr_mapped(s_axi_araddr_i))
				s_axi_rresp_o <= ADPM_RESP_DECERR;
			else if (!s_axi_aruser_i)
				s_axi_rresp_o <= ADPM_RESP_SLVERR;
			else if (addr_is(s_axi_araddr_i, ADPM_DIG_MODE_OFS))
				s_axi_rdata_o <= dig_mode_reg;
			else if (addr_is(s_axi_araddr_i, ADPM_DIG_PUD_OFS))
				s_axi_rdata_o <= dig_pud_reg;
			else if (addr_is(s_axi_araddr_i, ADPM_DIG_DATA_OFS))
				s_axi_rdata_o <= {24'h00_0000, dig_in_sync}; // [R9]
			else if (addr_is(s_axi_araddr_i, ADPM_DIG_DIR_OFS))
				s_axi_rdata_o <= dig_dir_reg;
			else if (addr_is(s_axi_araddr_i, ADPM_ANA_MODE_OFS))
				s_axi_rdata_o <= ana_mode_reg;
			else if (addr_is(s_axi_araddr_i, ADPM_ANA_DATA_OFS))
				s_axi_rdata_o <= {26'h000_0000, line_in}; // [R17]
			else
				s_axi_rdata_o <= ana_dir_reg;
		end
		else if (s_axi_rvalid_o && s_axi_rready_i)
		begin
			s_axi_rvalid_o  <= 1'b0;
			s_axi_arready_o <= 1'b1;
		end
	end

	// Digital group routing
	always_comb
	begin
		dig_next = '0;
		for (int i = 0; i < ADPM_DIG_PINS; i++)
		begin
			dig_next.pullup_en[i] = !dig_pud_reg[i]; // [R2]
			if (dig_mode_reg[2*i +: 2] == ADPM_MODE_GPIO) // [R8]
			begin
				dig_next.oe[i]  = dig_dir_reg[i]; // [R19]
				dig_next.out[i] = dig_data_reg[i] && dig_dir_reg[i];
			end
			else if (dig_mode_reg[2*i +: 2] == ADPM_MODE_COMP && ADPM_DIG_COMP[i] >= 0)
			begin
				dig_next.oe[i]  = 1'b1; // [R1] [R6] [R8]
				dig_next.out[i] = comparator_output_i[ADPM_DIG_COMP[i]];
			end
			// Modes 1 and 2, and mode 3 without a comparator, leave the pin idle [R7]
		end
	end

	// Analog group routing: odd bit 2*channel+1 picks analog or digital
	always_comb
	begin
		ana_next = '0;
		for (int p = 0; p < ADPM_ANA_PINS; p++)
		begin
			ana_next.analog_sel[p] = ana_mode_reg[2*ADPM_ANA_CHAN[p]+1]; // [R13] [R15]
			if (!ana_mode_reg[2*ADPM_ANA_CHAN[p]+1] && ADPM_ANA_LINE[p] >= 0) // [R16]
			begin
				ana_next.oe[p]  = ana_dir_reg[ADPM_ANA_LINE[p]]; // [R10] [R19]
				ana_next.out[p] = ana_data_reg[ADPM_ANA_LINE[p]] && ana_dir_reg[ADPM_ANA_LINE[p]];
			end
		end
	end

	always_ff @(posedge mclk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			digital_pin_group_o <= '0;
			analog_pin_group_o  <= '0;
		end
		else
		begin
			digital_pin_group_o <= dig_next;
			analog_pin_group_o  <= ana_next;
		end
	end
endmodule
`default_nettype wire

/* File: adpm_pin_mux_asserts.sv */
// Checker for the pin mux: bus answers, refusals and analog pin drive.
// Assumes it is bound into adpm_pin_mux and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module adpm_pin_mux_asserts (
	input wire logic                      mclk_i,
	input wire logic                      arst_n_i,
	input wire logic [7:0]                s_axi_awaddr_i,
	input wire logic                      s_axi_awuser_i,
	input wire logic                      s_axi_awvalid_i,
	input wire logic                      s_axi_awready_o,
	input wire logic                      s_axi_wvalid_i,
	input wire logic                      s_axi_wready_o,
	input wire logic [1:0]                s_axi_bresp_o,
	input wire logic                      s_axi_bvalid_o,
	input wire logic                      s_axi_bready_i,
	input wire logic [7:0]                s_axi_araddr_i,
	input wire logic                      s_axi_aruser_i,
	input wire logic                      s_axi_arvalid_i,
	input wire logic                      s_axi_arready_o,
	input wire logic [31:0]               s_axi_rdata_o,
	input wire logic [1:0]                s_axi_rresp_o,
	input wire logic                      s_axi_rvalid_o,
	input wire logic                      s_axi_rready_i,
	input wire adpm_pkg::adpm_ana_drive_t analog_pin_group_o
);
	import adpm_pkg::*;
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!arst_n_i);
	sequence wr_taken;
		s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
	endsequence
	sequence rd_taken;
		s_axi_arvalid_i && s_axi_arready_o;
	endsequence
	// Both halves held after the take edge; the response rises one edge later
	a_write_answer: assert property (
		wr_taken |-> ##2 s_axi_bvalid_o) else $error("write not answered");
	a_write_refused: assert property (
		wr_taken ##0 (!s_axi_awuser_i && s_axi_awaddr_i <= ADPM_ANA_DIR_OFS)
		|-> ##2 s_axi_bvalid_o && s_axi_bresp_o == ADPM_RESP_SLVERR) else $error("write not refused");
	a_read_answer: assert property (
		rd_taken |=> s_axi_rvalid_o) else $error("read not answered");
	a_read_refused: assert property (
		rd_taken ##0 (!s_axi_aruser_i && s_axi_araddr_i <= ADPM_ANA_DIR_OFS)
		|=> s_axi_rdata_o == 32'h0 && s_axi_rresp_o == ADPM_RESP_SLVERR) else $error("read leaked");
	a_resp_hold: assert property (
		s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
		else $error("write response dropped");
	a_rdata_hold: assert property (
		s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
		else $error("read data dropped");
	a_write_busy: assert property (
		s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o) else $error("second write taken");
	a_read_busy: assert property (
		s_axi_rvalid_o |-> !s_axi_arready_o) else $error("second read taken");
	a_sel_no_drive: assert property (
		(analog_pin_group_o.oe & analog_pin_group_o.analog_sel) == 12'h000)
		else $error("analog pin driven");
	a_unlined_idle: assert property (
		(analog_pin_group_o.oe & 12'h965) == 12'h000) else $error("pin without line driven");
endmodule
bind adpm_pin_mux adpm_pin_mux_asserts u_adpm_pin_mux_asserts (.mclk_i, .arst_n_i,
	.s_axi_awaddr_i, .s_axi_awuser_i, .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wvalid_i,
	.s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_araddr_i,
	.s_axi_aruser_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o,
	.s_axi_rvalid_o, .s_axi_rready_i, .analog_pin_group_o);
`default_nettype wire

/* File: adpm_pkg.sv */
// Function
// R1: Each of eight digital-group pins routes to input, output or a comparator output.
// R2: Writing 1 to a pin's pullup-disable bit turns that pin's pullup off.
// R3: After reset every digital-group pin is undriven, with its digital function disabled.
// R4: Digital-group configuration changes only on accesses from the control CPU.
// R5: Each digital pin has a 2-bit mode field; 00..11 select modes 0..3.
// R6: Bits 5:4 steer the third pin: 00 gives GPIO, 11 gives comparator 6.
// R7: Modes 1 and 2 of the digital group are reserved and do nothing.
// R8: Mode 3 maps pins 2,3,4,5,6,8 to comparators 1,6,2,3,4,5; mode 0 is GPIO.
// R9: Software reads and writes eight digital data bits and sets each direction.
// R10: Each of twelve analog pins feeds converter/comparator inputs or acts as plain GPIO.
// R11: After reset every analog-group pin is an analog input, digital function off.
// R12: Analog-group configuration changes only on accesses from the control CPU.
// R13: Analog mode uses one odd bit per pin: 0 digital mode, 1 analog mode.
// R14: Even bits of the analog mode register are ignored.
// R15: Bit 5 steers the second analog pin: 0 digital line 2, 1 analog inputs.
// R16: Only six analog pins have digital lines 2,4,6,10,12,14 in mode 0.
// R17: Software reads and writes the six digital line bits and sets each direction.
// R18: Software enables only one of converter or comparator input sharing a pin.
// R19: A pin drives only in GPIO output mode or comparator-output mode.
// Package of constants and types for the analog/digital pin mux.
// Assumes a 32-bit AXI4-Lite register bus on the system clock.
package adpm_pkg;

	localparam int ADPM_DIG_PINS = 8;
	localparam int ADPM_ANA_PINS = 12;
	localparam int ADPM_LINES    = 6;
	localparam int ADPM_COMPS    = 6;
	localparam int ADPM_AW       = 8;

	// Register byte offsets
	localparam logic [ADPM_AW-1:0] ADPM_DIG_MODE_OFS = 8'h00;
	localparam logic [ADPM_AW-1:0] ADPM_DIG_PUD_OFS  = 8'h04;
	localparam logic [ADPM_AW-1:0] ADPM_DIG_DATA_OFS = 8'h08;
	localparam logic [ADPM_AW-1:0] ADPM_DIG_DIR_OFS  = 8'h0c;
	localparam logic [ADPM_AW-1:0] ADPM_ANA_MODE_OFS = 8'h10;
	localparam logic [ADPM_AW-1:0] ADPM_ANA_DATA_OFS = 8'h14;
	localparam logic [ADPM_AW-1:0] ADPM_ANA_DIR_OFS  = 8'h18;

	// Reset values: digital pins in reserved mode 01, analog odd bits set
	localparam logic [31:0] ADPM_DIG_MODE_RST = 32'h0000_5555;
	localparam logic [31:0] ADPM_DIG_MODE_MSK = 32'h0000_ffff;
	localparam logic [31:0] ADPM_DIG_PUD_RST  = 32'h0000_0000;
	localparam logic [31:0] ADPM_DIG_8_MSK    = 32'h0000_00ff;
	localparam logic [31:0] ADPM_ANA_MODE_RST = 32'haaaa_aaaa;
	localparam logic [31:0] ADPM_ANA_MODE_MSK = 32'haaaa_aaaa;
	localparam logic [31:0] ADPM_LINE_MSK     = 32'h0000_003f;
	localparam logic [31:0] ADPM_DIR_RST      = 32'h0000_0000;

	localparam logic [1:0] ADPM_MODE_GPIO = 2'h0;
	localparam logic [1:0] ADPM_MODE_COMP = 2'h3;

	localparam logic [1:0] ADPM_RESP_OKAY   = 2'h0;
	localparam logic [1:0] ADPM_RESP_SLVERR = 2'h2;
	localparam logic [1:0] ADPM_RESP_DECERR = 2'h3;

	// Comparator index per digital pin in mode 3, -1 for none
	localparam int ADPM_DIG_COMP [ADPM_DIG_PINS] = '{-1, 0, 5, 1, 2, 3, -1, 4};
	// Channel number of each analog pin (A0,A2,A3,A4,A6,A7,B0,B2,B3,B4,B6,B7)
	localparam int ADPM_ANA_CHAN [ADPM_ANA_PINS] = '{0, 2, 3, 4, 6, 7, 8, 10, 11, 12, 14, 15};
	// Digital line bit per analog pin, -1 for none (lines 2,4,6,10,12,14)
	localparam int ADPM_ANA_LINE [ADPM_ANA_PINS] = '{-1, 0, -1, 1, 2, -1, -1, 3, -1, 4, 5, -1};

	typedef struct packed {
		logic [ADPM_DIG_PINS-1:0] out;
		logic [ADPM_DIG_PINS-1:0] oe;
		logic [ADPM_DIG_PINS-1:0] pullup_en;
	} adpm_dig_drive_t;

	typedef struct packed {
		logic [ADPM_ANA_PINS-1:0] out;
		logic [ADPM_ANA_PINS-1:0] oe;
		logic [ADPM_ANA_PINS-1:0] analog_sel;
	} adpm_ana_drive_t;

endpackage

/* File: adpm_sync3.sv */
// Three-stage input synchroniser for pin levels.
// Assumes asynchronous inputs; output updates when stages two and three agree.
`timescale 1ns/1ps
`default_nettype none
module adpm_sync3 #(
	parameter int W = 8
) (
	input  wire logic         mclk_i,
	input  wire logic         arst_n_i,
	input  wire logic [W-1:0] async_i,
	output var  logic [W-1:0] level_o
);
	logic [W-1:0] s1_reg;
	logic [W-1:0] s2_reg;
	logic [W-1:0] s3_reg;

	always_ff @(posedge mclk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			s1_reg <= '0;
			s2_reg <= '0;
			s3_reg <= '0;
		end
		else
		begin
			s1_reg <= async_i;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
		end
	end

	// Per bit, a level is taken only once it has held for two samples
	genvar g;
	generate
		for (g = 0; g < W; g++)
		begin : g_bit
			always_ff @(posedge mclk_i or negedge arst_n_i)
			begin
				if (!arst_n_i)
					level_o[g] <= 1'b0;
				else if (s2_reg[g] == s3_reg[g])
					level_o[g] <= s3_reg[g];
			end
		end
	endgenerate
endmodule
`default_nettype wire

/* File: tb_top.sv */
// Bench for the pin mux: reset state, pin routing and register access.
// Assumes the package, pad model and bound checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin miscompares++; \
	$display("[FAIL] %0t got %h exp %h", $time, (g), (e)); end end
module tb_top;
	import adpm_pkg::*;
	logic            mclk_i = 1'b0;
	logic            arst_n_i = 1'b0;
	logic [7:0]      awaddr = 8'h00;
	logic [7:0]      araddr = 8'h00;
	logic [31:0]     wdata = 32'h0;
	logic            awuser = 1'b0;
	logic            awvalid = 1'b0;
	logic            wvalid = 1'b0;
	logic            bready = 1'b0;
	logic            aruser = 1'b0;
	logic            arvalid = 1'b0;
	logic            rready = 1'b0;
	logic            awready, wready, bvalid, arready, rvalid;
	logic [1:0]      bresp, rresp;
	logic [31:0]     rdata;
	logic [5:0]      cmp_set = 6'h25;
	logic [5:0]      cmp;
	logic [7:0]      dig_ext = 8'h00;
	logic [7:0]      dig_pad;
	logic [11:0]     ana_ext = 12'h000;
	logic [11:0]     ana_pad;
	adpm_dig_drive_t dig;
	adpm_ana_drive_t ana;
	int              miscompares = 0;
	int              tests_run = 0;
	always #5 mclk_i = ~mclk_i;
	adpm_pin_mux u_adpm_pin_mux (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .s_axi_awaddr_i(awaddr),
		.s_axi_awuser_i(awuser), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
		.s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wvalid),
		.s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
		.s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_aruser_i(aruser),
		.s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
		.s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
		.comparator_output_i(cmp), .digital_pin_group_i(dig_pad), .digital_pin_group_o(dig),
		.analog_pin_group_i(ana_pad), .analog_pin_group_o(ana));
	adpm_pad_model u_adpm_pad_model (.dig_drv_i(dig), .ana_drv_i(ana), .cmp_set_i(cmp_set),
		.dig_ext_i(dig_ext), .ana_ext_i(ana_ext), .cmp_o(cmp), .dig_pad_o(dig_pad),
		.ana_pad_o(ana_pad));
	task automatic end_sim;
		$display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// Bready rises late so the response must be held for a cycle
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic u, input logic [1:0] e);
		int n;
		n = 0;
		@(posedge mclk_i);
		awaddr <= a;
		wdata <= d;
		awuser <= u;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		do
		begin
			@(posedge mclk_i);
			n++;
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid && !bready) bready <= 1'b1;
		end while (!(bvalid && bready) && n < 40);
		bready <= 1'b0;
		`CHK(n < 40, 1'b1)
		`CHK(bresp, e)
	endtask
	task automatic rd(input logic [7:0] a, input logic u, input logic [31:0] d, input logic [1:0] e);
		int n;
		n = 0;
		@(posedge mclk_i);
		araddr <= a;
		aruser <= u;
		arvalid <= 1'b1;
		do
		begin
			@(posedge mclk_i);
			n++;
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid && !rready) rready <= 1'b1;
		end while (!(rvalid && rready) && n < 40);
		rready <= 1'b0;
		`CHK(n < 40, 1'b1)
		`CHK(rdata, d)
		`CHK(rresp, e)
	endtask
	task automatic t_reset;
		`CHK(dig.oe, 8'h00)
		`CHK(dig.pullup_en, 8'hff)
		`CHK(ana.analog_sel, 12'hfff)
		`CHK(ana.oe, 12'h000)
		rd(ADPM_DIG_MODE_OFS, 1'b1, 32'h0000_5555, ADPM_RESP_OKAY);
		rd(ADPM_DIG_DIR_OFS, 1'b1, 32'h0, ADPM_RESP_OKAY);
		rd(ADPM_ANA_MODE_OFS, 1'b1, 32'haaaa_aaaa, ADPM_RESP_OKAY);
	endtask
	task automatic t_dig;
		int map [8] = '{-1, 0, 5, 1, 2, 3, -1, 4};
		logic [7:0] eo;
		logic [7:0] ev;
		wr(ADPM_DIG_DIR_OFS, 32'h39, 1'b1, ADPM_RESP_OKAY);
		wr(ADPM_DIG_DATA_OFS, 32'hff, 1'b1, ADPM_RESP_OKAY);
		for (int m = 0; m < 4; m++)
		begin
			wr(ADPM_DIG_MODE_OFS, {16'h0, {8{2'(m)}}}, 1'b1, ADPM_RESP_OKAY);
			repeat (2) @(posedge mclk_i);
			for (int i = 0; i < 8; i++)
			begin
				eo[i] = (m == 0) ? (8'h39 >> i) & 1'b1 : (m == 3 && map[i] >= 0);
				ev[i] = (m == 3 && map[i] >= 0) ? cmp_set[map[i]] : (m == 0 && eo[i]);
			end
			`CHK(dig.oe, eo)
			`CHK(dig.out & eo, ev)
		end
		wr(ADPM_DIG_MODE_OFS, 32'h30, 1'b1, ADPM_RESP_OKAY);
		repeat (2) @(posedge mclk_i);
		`CHK(dig.oe, 8'h3d)
		`CHK(dig.out, 8'h3d)
	endtask
	task automatic t_access;
		wr(ADPM_DIG_MODE_OFS, 32'h0, 1'b0, ADPM_RESP_SLVERR);
		wr(ADPM_ANA_MODE_OFS, 32'h0, 1'b0, ADPM_RESP_SLVERR);
		rd(ADPM_DIG_MODE_OFS, 1'b0, 32'h0, ADPM_RESP_SLVERR);
		rd(ADPM_DIG_MODE_OFS, 1'b1, 32'h30, ADPM_RESP_OKAY);
		rd(ADPM_ANA_MODE_OFS, 1'b1, 32'haaaa_aaaa, ADPM_RESP_OKAY);
		wr(8'h40, 32'h1, 1'b1, ADPM_RESP_DECERR);
		rd(8'h40, 1'b1, 32'h0, ADPM_RESP_DECERR);
	endtask
	task automatic t_pullup;
		wr(ADPM_DIG_DIR_OFS, 32'h0, 1'b1, ADPM_RESP_OKAY);
		wr(ADPM_DIG_MODE_OFS, 32'h0, 1'b1, ADPM_RESP_OKAY);
		wr(ADPM_DIG_PUD_OFS, 32'hffff_ff81, 1'b1, ADPM_RESP_OKAY);
		repeat (6) @(posedge mclk_i);
		`CHK(dig.pullup_en, 8'h7e)
		rd(ADPM_DIG_PUD_OFS, 1'b1, 32'h81, ADPM_RESP_OKAY);
		rd(ADPM_DIG_DATA_OFS, 1'b1, 32'h7e, ADPM_RESP_OKAY);
	endtask
	task automatic t_ana;
		wr(ADPM_ANA_MODE_OFS, 32'h5555_5555, 1'b1, ADPM_RESP_OKAY);
		rd(ADPM_ANA_MODE_OFS, 1'b1, 32'h0, ADPM_RESP_OKAY);
		`CHK(ana.analog_sel, 12'h000)
		wr(ADPM_ANA_DIR_OFS, 32'h3f, 1'b1, ADPM_RESP_OKAY);
		wr(ADPM_ANA_DATA_OFS, 32'h15, 1'b1, ADPM_RESP_OKAY);
		repeat (2) @(posedge mclk_i);
		`CHK(ana.oe, 12'h69a)
		`CHK(ana.out, 12'h212)
		wr(ADPM_ANA_MODE_OFS, 32'h20, 1'b1, ADPM_RESP_OKAY);
		repeat (2) @(posedge mclk_i);
		`CHK(ana.analog_sel, 12'h002)
		`CHK(ana.oe, 12'h698)
		wr(ADPM_ANA_DIR_OFS, 32'h0, 1'b1, ADPM_RESP_OKAY);
		ana_ext <= 12'h208;
		repeat (6) @(posedge mclk_i);
		rd(ADPM_ANA_DATA_OFS, 1'b1, 32'h12, ADPM_RESP_OKAY);
	endtask
	initial
	begin
		repeat (5) @(posedge mclk_i);
		arst_n_i <= 1'b1;
		repeat (2) @(posedge mclk_i);
		t_reset();
		t_dig();
		t_access();
		t_pullup();
		t_ana();
		// Reset again in mid-run: configuration must fall back to its reset state
		arst_n_i <= 1'b0;
		repeat (2) @(posedge mclk_i);
		arst_n_i <= 1'b1;
		repeat (2) @(posedge mclk_i);
		t_reset();
		end_sim();
	end
	initial
	begin
		repeat (20000) @(posedge mclk_i);
		miscompares++;
		end_sim();
	end
endmodule
`default_nettype wire
